/* File: rtl/cfp_pkg.sv */
package cfp_pkg;
  // ==========================================================================
  // Register offsets
  localparam logic [7:0] OVERCURRENT_LIMIT_SEL_OFS = 8'h15;
  localparam logic [7:0] OVERVOLTAGE_LEVEL_SEL_OFS = 8'h17;
  localparam logic [7:0] OVERTEMP_LEVEL_SEL_OFS    = 8'h19;
  localparam logic [7:0] BUS_ID_BASE_OFS           = 8'h1E;
  localparam logic [7:0] FAULT_STATUS_OFS          = 8'h1F;
  // ==========================================================================
  // Reset values
  localparam logic [7:0] BUS_ID_BASE_RST  = 8'h08;
  localparam logic [2:0] OC_SEL_RST       = 3'h2;
  localparam logic [1:0] OV_SEL_RST       = 2'h3;
  localparam logic [1:0] OT_SEL_RST       = 2'h3;
  localparam logic [7:0] UNMAPPED_RD      = 8'h00;
  // ==========================================================================
  // Field widths
  localparam int OC_SEL_W  = 3;
  localparam int LVL_SEL_W = 2;
  localparam int OFS_W     = 3;
  // ==========================================================================
  // Threshold codes (the analog side turns these into levels)
  localparam logic [1:0] OC_CODE_4A      = 2'h0;
  localparam logic [1:0] OC_CODE_6A      = 2'h1;
  localparam logic [1:0] OC_CODE_DEFAULT = 2'h2;
  // Over-voltage percent of target
  localparam logic [7:0] OV_PCT_0 = 8'd105;
  localparam logic [7:0] OV_PCT_1 = 8'd110;
  localparam logic [7:0] OV_PCT_2 = 8'd115;
  localparam logic [7:0] OV_PCT_3 = 8'd120;
  localparam logic [7:0] OV_HYST_PCT = 8'd5;
  // Over-temperature trip in degrees C
  localparam logic [7:0] OT_DEG_0 = 8'd75;
  localparam logic [7:0] OT_DEG_1 = 8'd85;
  localparam logic [7:0] OT_DEG_2 = 8'd125;
  localparam logic [7:0] OT_DEG_3 = 8'd145;
  localparam logic [7:0] OT_HYST_DEG = 8'd25;
  // ==========================================================================
  // Timing
  localparam int CLK_HZ       = 40_000_000;
  localparam int CLK_PERIOD_PS = 25_000;
  localparam int TON_MIN_NS   = 30;
  localparam int TOFF_MIN_NS  = 120;
  localparam int OV_FILT_NS   = 5_000;
  localparam int TON_MIN_CYC  = (TON_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TOFF_MIN_CYC = (TOFF_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int OV_FILT_CYC  = (OV_FILT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int HICCUP_CYC_DEF = 4096;
  // ==========================================================================
  // Supervisor states, Gray on ST_OFF-ST_SOFT-ST_RUN-ST_OC_DRAIN-ST_HICCUP; steps such as ST_HICCUP to ST_SOFT change more bits
  typedef enum logic [2:0] {
    ST_OFF      = 3'b000,
    ST_SOFT     = 3'b001,
    ST_RUN      = 3'b011,
    ST_OC_DRAIN = 3'b010,
    ST_HICCUP   = 3'b110,
    ST_OV_LATCH = 3'b111,
    ST_OT_WAIT  = 3'b101
  } cfp_state_t;
  // Switching phase
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_ON   = 2'b01,
    PH_OFF  = 2'b11
  } cfp_phase_t;
endpackage : cfp_pkg

/* File: rtl/cfp_supervisor.sv */
`timescale 1ns/1ps
module cfp_supervisor #(
  parameter int HICCUP_CYC = cfp_pkg::HICCUP_CYC_DEF
) (
  input  wire logic       i_core_clk,
  input  wire logic       i_rst,
  input  wire logic       i_run_ctrl,
  input  wire logic [2:0] i_strap_offset,
  input  wire logic       i_strap_valid,
  input  wire logic       i_reg_wr,
  input  wire logic       i_reg_rd,
  input  wire logic [7:0] i_reg_addr,
  input  wire logic [7:0] i_reg_wdata,
  input  wire logic       i_pwm_demand,
  input  wire logic       i_ramp_done,
  input  wire logic       i_sense_low,
  input  wire logic       i_oc_trip,
  input  wire logic       i_zero_current,
  input  wire logic       i_ov_trip,
  input  wire logic       i_ov_clear,
  input  wire logic       i_ot_trip,
  input  wire logic       i_ot_clear,
  output logic [7:0]      o_reg_rdata,
  output logic [7:0]      o_bus_id,
  output logic            o_bus_id_valid,
  output logic            o_hs_gate,
  output logic            o_ls_gate,
  output logic            o_ramp_enable,
  output logic            o_output_good_flag,
  output logic            o_bias_enable,
  output logic [1:0]      o_oc_code,
  output logic [7:0]      o_ov_pct,
  output logic [7:0]      o_ov_release_pct,
  output logic [7:0]      o_ot_deg,
  output logic [7:0]      o_ot_release_deg,
  output logic            o_fault_event
);

  // ==========================================================================
  // Decoders
  function automatic logic [1:0] oc_decode(input logic [2:0] sel);
    case (sel)
      3'h0:    oc_decode = cfp_pkg::OC_CODE_4A;
      3'h1:    oc_decode = cfp_pkg::OC_CODE_6A;
      default: oc_decode = cfp_pkg::OC_CODE_DEFAULT;
    endcase
  endfunction : oc_decode

  function automatic logic [7:0] ov_decode(input logic [1:0] sel);
    case (sel)
      2'h0:    ov_decode = cfp_pkg::OV_PCT_0;
      2'h1:    ov_decode = cfp_pkg::OV_PCT_1;
      2'h2:    ov_decode = cfp_pkg::OV_PCT_2;
      default: ov_decode = cfp_pkg::OV_PCT_3;
    endcase
  endfunction : ov_decode

  function automatic logic [7:0] ot_decode(input logic [1:0] sel);
    case (sel)
      2'h0:    ot_decode = cfp_pkg::OT_DEG_0;
      2'h1:    ot_decode = cfp_pkg::OT_DEG_1;
      2'h2:    ot_decode = cfp_pkg::OT_DEG_2;
      default: ot_decode = cfp_pkg::OT_DEG_3;
    endcase
  endfunction : ot_decode

  // ==========================================================================
  // Input synchronisers, three stages, change when stages two and three agree
  localparam int NSYNC = 8;
  logic [NSYNC-1:0] async_in;
  logic [NSYNC-1:0] sync_s1;
  logic [NSYNC-1:0] sync_s2;
  logic [NSYNC-1:0] sync_s3;
  logic [NSYNC-1:0] clean;
  assign async_in = {i_run_ctrl, i_sense_low, i_oc_trip, i_zero_current,
                     i_ov_trip, i_ov_clear, i_ot_trip, i_ot_clear};

  genvar g;
  generate
    for (g = 0; g < NSYNC; g++) begin : g_sync
      always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
          sync_s1[g] <= 1'b0;
          sync_s2[g] <= 1'b0;
          sync_s3[g] <= 1'b0;
          clean[g]   <= 1'b0;
        end else begin
          sync_s1[g] <= async_in[g];
          sync_s2[g] <= sync_s1[g];
          sync_s3[g] <= sync_s2[g];
          if (sync_s2[g] == sync_s3[g]) begin
            clean[g] <= sync_s3[g];
          end
        end
      end
    end
  endgenerate

  logic run_s, sense_low_s, oc_s, zero_s, ov_s, ov_clr_s, ot_s, ot_clr_s;
  assign {run_s, sense_low_s, oc_s, zero_s, ov_s, ov_clr_s, ot_s, ot_clr_s} = clean;

  // ==========================================================================
  // Registers
  logic [7:0]                   bus_id_base_reg;
  logic [cfp_pkg::OC_SEL_W-1:0] oc_sel_reg;
  logic [cfp_pkg::LVL_SEL_W-1:0] ov_sel_reg;
  logic [cfp_pkg::LVL_SEL_W-1:0] ot_sel_reg;

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      bus_id_base_reg <= cfp_pkg::BUS_ID_BASE_RST;
      oc_sel_reg      <= cfp_pkg::OC_SEL_RST;
      ov_sel_reg      <= cfp_pkg::OV_SEL_RST;
      ot_sel_reg      <= cfp_pkg::OT_SEL_RST;
    end else if (i_reg_wr) begin
      case (i_reg_addr)
        cfp_pkg::BUS_ID_BASE_OFS:           bus_id_base_reg <= i_reg_wdata;
        cfp_pkg::OVERCURRENT_LIMIT_SEL_OFS: oc_sel_reg <= i_reg_wdata[2:0];
        cfp_pkg::OVERVOLTAGE_LEVEL_SEL_OFS: ov_sel_reg <= i_reg_wdata[1:0];
        cfp_pkg::OVERTEMP_LEVEL_SEL_OFS:    ot_sel_reg <= i_reg_wdata[1:0];
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // Address offset, caught once after reset
  logic [cfp_pkg::OFS_W-1:0] offset_reg;
  logic                      offset_done_reg;

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      offset_reg      <= '0;
      offset_done_reg <= 1'b0;
    end else if (!offset_done_reg && i_strap_valid) begin
      offset_reg      <= i_strap_offset;
      offset_done_reg <= 1'b1;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_bus_id       <= 8'h00;
      o_bus_id_valid <= 1'b0;
    end else begin
      o_bus_id       <= bus_id_base_reg + {5'h00, offset_reg};
      o_bus_id_valid <= offset_done_reg;
    end
  end

  // ==========================================================================
  // Threshold outputs
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_oc_code        <= 2'h0;
      o_ov_pct         <= 8'h00;
      o_ov_release_pct <= 8'h00;
      o_ot_deg         <= 8'h00;
      o_ot_release_deg <= 8'h00;
    end else begin
      o_oc_code        <= oc_decode(oc_sel_reg);
      o_ov_pct         <= ov_decode(ov_sel_reg);
      o_ov_release_pct <= ov_decode(ov_sel_reg) - cfp_pkg::OV_HYST_PCT;
      o_ot_deg         <= ot_decode(ot_sel_reg);
      o_ot_release_deg <= ot_decode(ot_sel_reg) - cfp_pkg::OT_HYST_DEG;
    end
  end

  // ==========================================================================
  // Over-voltage filter
  logic [15:0] ov_cnt_reg;
  logic        ov_fault;
  assign ov_fault = (ov_cnt_reg == 16'(cfp_pkg::OV_FILT_CYC));

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      ov_cnt_reg <= '0;
    end else if (!ov_s) begin
      ov_cnt_reg <= '0;
    end else if (!ov_fault) begin
      ov_cnt_reg <= ov_cnt_reg + 16'h0001;
    end
  end

  // ==========================================================================
  // Supervisor state machine
  cfp_pkg::cfp_state_t state_reg;
  cfp_pkg::cfp_phase_t phase_reg;
  logic [31:0]         blank_cnt_reg;
  logic                ls_discharge_reg;

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg     <= cfp_pkg::ST_OFF;
      blank_cnt_reg <= '0;
    end else if (!run_s) begin
      state_reg     <= cfp_pkg::ST_OFF;
      blank_cnt_reg <= '0;
    end else begin
      case (state_reg)
        cfp_pkg::ST_OFF: begin
          state_reg <= cfp_pkg::ST_SOFT;
        end
        cfp_pkg::ST_SOFT, cfp_pkg::ST_RUN: begin
          if (ov_fault) begin
            state_reg <= cfp_pkg::ST_OV_LATCH;
          end else if (ot_s) begin
            state_reg <= cfp_pkg::ST_OT_WAIT;
          end else if (oc_s && phase_reg == cfp_pkg::PH_OFF) begin
            state_reg <= cfp_pkg::ST_OC_DRAIN;
          end else if (state_reg == cfp_pkg::ST_SOFT && i_ramp_done) begin
            state_reg <= cfp_pkg::ST_RUN;
          end
        end
        cfp_pkg::ST_OC_DRAIN: begin
          if (ov_fault) begin
            state_reg <= cfp_pkg::ST_OV_LATCH;
          end else if (zero_s) begin
            state_reg     <= cfp_pkg::ST_HICCUP;
            blank_cnt_reg <= '0;
          end
        end
        cfp_pkg::ST_HICCUP: begin
          if (ov_fault) begin
            state_reg <= cfp_pkg::ST_OV_LATCH;
          end else if (blank_cnt_reg == 32'(HICCUP_CYC - 1)) begin
            state_reg <= cfp_pkg::ST_SOFT;
          end else begin
            blank_cnt_reg <= blank_cnt_reg + 32'h0000_0001;
          end
        end
        cfp_pkg::ST_OT_WAIT: begin
          if (ov_fault) begin
            state_reg <= cfp_pkg::ST_OV_LATCH;
          end else if (ot_clr_s) begin
            state_reg <= cfp_pkg::ST_SOFT;
          end
        end
        cfp_pkg::ST_OV_LATCH: begin
          state_reg <= cfp_pkg::ST_OV_LATCH;
        end
        default: state_reg <= cfp_pkg::ST_OFF;
      endcase
    end
  end

  // Low-side discharge while latched, released below hysteresis level
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      ls_discharge_reg <= 1'b0;
    end else if (state_reg != cfp_pkg::ST_OV_LATCH) begin
      ls_discharge_reg <= 1'b1;
    end else if (ov_clr_s) begin
      ls_discharge_reg <= 1'b0;
    end
  end

  // ==========================================================================
  // Switching phase: minimum on and off times
  logic [7:0]          phase_cnt_reg;
  logic                active;
  logic                switching;
  logic                sense_low_hold;
  assign active    = run_s && (state_reg == cfp_pkg::ST_SOFT || state_reg == cfp_pkg::ST_RUN);
  assign switching = active && !ov_fault && !ot_s;
  assign sense_low_hold = sense_low_s && state_reg == cfp_pkg::ST_SOFT;

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      phase_reg     <= cfp_pkg::PH_IDLE;
      phase_cnt_reg <= '0;
    end else if (!switching) begin
      phase_reg     <= cfp_pkg::PH_IDLE;
      phase_cnt_reg <= '0;
    end else begin
      case (phase_reg)
        cfp_pkg::PH_IDLE: begin
          phase_reg     <= cfp_pkg::PH_ON;
          phase_cnt_reg <= '0;
        end
        cfp_pkg::PH_ON: begin
          if (phase_cnt_reg >= 8'(cfp_pkg::TON_MIN_CYC - 1) &&
              (!i_pwm_demand || sense_low_hold)) begin
            phase_reg     <= cfp_pkg::PH_OFF;
            phase_cnt_reg <= '0;
          end else begin
            phase_cnt_reg <= phase_cnt_reg + 8'h01;
          end
        end
        cfp_pkg::PH_OFF: begin
          if (phase_cnt_reg >= 8'(cfp_pkg::TOFF_MIN_CYC - 1) && i_pwm_demand) begin
            phase_reg     <= cfp_pkg::PH_ON;
            phase_cnt_reg <= '0;
          end else if (phase_cnt_reg != 8'hFF) begin
            phase_cnt_reg <= phase_cnt_reg + 8'h01;
          end
        end
        default: phase_reg <= cfp_pkg::PH_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Gate and status outputs, faults act combinationally
  always_comb begin
    o_hs_gate = switching && phase_reg == cfp_pkg::PH_ON;
    case (state_reg)
      cfp_pkg::ST_OC_DRAIN: o_ls_gate = run_s && !ov_fault;
      cfp_pkg::ST_OV_LATCH: o_ls_gate = run_s && ls_discharge_reg;
      default: o_ls_gate = (switching && phase_reg == cfp_pkg::PH_OFF) ||
                           (run_s && ov_fault && !ot_s);
    endcase
    o_ramp_enable      = switching && !oc_s;
    o_output_good_flag = state_reg == cfp_pkg::ST_RUN && switching && !oc_s;
  end

  assign o_bias_enable = 1'b1;

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_fault_event <= 1'b0;
    end else begin
      o_fault_event <= active && (oc_s || ov_fault || ot_s);
    end
  end

  // ==========================================================================
  // Register read
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_reg_rdata <= cfp_pkg::UNMAPPED_RD;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        cfp_pkg::BUS_ID_BASE_OFS:           o_reg_rdata <= bus_id_base_reg;
        cfp_pkg::OVERCURRENT_LIMIT_SEL_OFS: o_reg_rdata <= {5'h00, oc_sel_reg};
        cfp_pkg::OVERVOLTAGE_LEVEL_SEL_OFS: o_reg_rdata <= {6'h00, ov_sel_reg};
        cfp_pkg::OVERTEMP_LEVEL_SEL_OFS:    o_reg_rdata <= {6'h00, ot_sel_reg};
        cfp_pkg::FAULT_STATUS_OFS:          o_reg_rdata <= {5'h00, state_reg};
        default:                            o_reg_rdata <= cfp_pkg::UNMAPPED_RD;
      endcase
    end
  end

endmodule : cfp_supervisor

/* File: bench/cfp_supervisor_props.sv */
`timescale 1ns/1ps
// ==========================================================================
// Port checker for the supervisor
module cfp_props (
  input wire logic       i_core_clk,
  input wire logic       i_rst,
  input wire logic       i_run_ctrl,
  input wire logic       i_reg_wr,
  input wire logic       i_oc_trip,
  input wire logic       i_ov_trip,
  input wire logic       i_ov_clear,
  input wire logic       i_ot_trip,
  input wire logic [7:0] o_bus_id,
  input wire logic       o_bus_id_valid,
  input wire logic       o_hs_gate,
  input wire logic       o_ls_gate,
  input wire logic       o_ramp_enable,
  input wire logic       o_output_good_flag,
  input wire logic       o_bias_enable,
  input wire logic       o_fault_event
);
  logic [7:0] ov_cnt_reg;
  logic       ov_lat_reg;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  // ==========================================================================
  // Over-voltage run length and latch tracker
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) ov_cnt_reg <= 8'h00;
    else if (!i_ov_trip) ov_cnt_reg <= 8'h00;
    else if (ov_cnt_reg != 8'hFF) ov_cnt_reg <= ov_cnt_reg + 8'h01;
  end
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) ov_lat_reg <= 1'b0;
    else if (!i_run_ctrl) ov_lat_reg <= 1'b0;
    else if (ov_cnt_reg >= 8'hC8 && o_fault_event) ov_lat_reg <= 1'b1;
  end
  // ==========================================================================
  // Assertions
  AST_RUN_OFF:
    assert property ($fell(i_run_ctrl) |-> ##[1:5] (!o_hs_gate && !o_ls_gate && !o_ramp_enable))
      else $error("gates left on after run low");
  AST_TON:
    assert property ($rose(o_hs_gate) && i_run_ctrl && !i_ov_trip && !i_ot_trip |=> o_hs_gate)
      else $error("high-side pulse too short");
  AST_TOFF:
    assert property ($fell(o_hs_gate) |-> !o_hs_gate [*5]) else $error("off time too short");
  AST_OC_PG:
    assert property (i_oc_trip [*8] |=> ##2 !o_output_good_flag)
      else $error("output good kept during over-current");
  AST_OT_OFF:
    assert property ((i_ot_trip && !i_oc_trip && !ov_lat_reg) [*8] |->
      !o_hs_gate && !o_ls_gate && !o_ramp_enable && o_bias_enable)
      else $error("switching during thermal shutdown");
  AST_OV_DIS:
    assert property ((ov_lat_reg && !i_ov_clear) [*6] |->
      o_ls_gate && !o_hs_gate && !o_output_good_flag) else $error("no discharge in over-voltage");
  AST_OV_HOLD:
    assert property (ov_lat_reg |-> !o_hs_gate) else $error("high-side on while latched");
  AST_OV_REL:
    assert property ((ov_lat_reg && i_ov_clear) [*6] |-> !o_ls_gate)
      else $error("low-side kept on below release");
  AST_BUS_ID:
    assert property (o_bus_id_valid && !i_reg_wr && !$past(i_reg_wr) |=>
      o_bus_id_valid && $stable(o_bus_id)) else $error("bus id moved without a write");
  COV_OC: cover property (i_oc_trip && o_ls_gate);
  COV_OV: cover property (ov_lat_reg && i_ov_clear);
  COV_OT: cover property (i_ot_trip && !o_ramp_enable);
endmodule : cfp_props

bind cfp_supervisor cfp_props u_props (.i_core_clk, .i_rst, .i_run_ctrl, .i_reg_wr, .i_oc_trip,
  .i_ov_trip, .i_ov_clear, .i_ot_trip, .o_bus_id, .o_bus_id_valid, .o_hs_gate, .o_ls_gate,
  .o_ramp_enable, .o_output_good_flag, .o_bias_enable, .o_fault_event);

/* File: bench/cfp_power_model.sv */
`timescale 1ns/1ps
// ==========================================================================
// Switch stage, comparators and offset strap detector
module cfp_power_model (
  input  wire logic       i_core_clk,
  input  wire logic       i_rst,
  input  wire logic       i_hs_gate,
  input  wire logic       i_ls_gate,
  input  wire logic       i_ramp_enable,
  input  wire logic       i_oc_cmd,
  input  wire logic [1:0] i_ov_lvl,
  input  wire logic [1:0] i_ot_lvl,
  input  wire logic [9:0] i_strap_r,
  output logic      [2:0] o_strap_offset,
  output logic            o_strap_valid,
  output logic            o_pwm_demand,
  output logic            o_ramp_done,
  output logic            o_sense_low,
  output logic            o_oc_trip,
  output logic            o_zero_current,
  output logic            o_ov_trip,
  output logic            o_ov_clear,
  output logic            o_ot_trip,
  output logic            o_ot_clear
);
  localparam logic [9:0] R_TBL [8] = '{10'h000, 10'h064, 10'h0C8, 10'h12D,
                                       10'h186, 10'h1D6, 10'h230, 10'h2A8};
  logic [3:0] cur_reg;
  logic [3:0] ph_reg;
  logic [5:0] ramp_reg;
  logic [3:0] sv_reg;
  // Strap in tenths of a kilohm to offset
  always_comb begin
    o_strap_offset = 3'h0;
    for (int k = 0; k < 8; k++) if (i_strap_r == R_TBL[k]) o_strap_offset = k[2:0];
  end
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      cur_reg  <= 4'h0;
      ph_reg   <= 4'h0;
      ramp_reg <= 6'h00;
      sv_reg   <= 4'h0;
    end else begin
      if (i_hs_gate) cur_reg <= 4'h8;
      else if (i_ls_gate && cur_reg != 4'h0) cur_reg <= cur_reg - 4'h1;
      ph_reg <= (ph_reg == 4'h9) ? 4'h0 : ph_reg + 4'h1;
      if (!i_ramp_enable) ramp_reg <= 6'h00;
      else if (ramp_reg != 6'h28) ramp_reg <= ramp_reg + 6'h01;
      if (sv_reg != 4'h8) sv_reg <= sv_reg + 4'h1;
    end
  end
  assign o_strap_valid  = sv_reg == 4'h8;
  assign o_pwm_demand   = ph_reg < 4'h3;
  assign o_ramp_done    = ramp_reg == 6'h28;
  assign o_sense_low    = ramp_reg < 6'h0A;
  assign o_oc_trip      = i_oc_cmd && cur_reg != 4'h0;
  assign o_zero_current = cur_reg == 4'h0;
  assign o_ov_trip      = i_ov_lvl == 2'h2;
  assign o_ov_clear     = i_ov_lvl == 2'h0;
  assign o_ot_trip      = i_ot_lvl == 2'h2;
  assign o_ot_clear     = i_ot_lvl == 2'h0;
endmodule : cfp_power_model

/* File: bench/cfp_supervisor_bench.sv */
`timescale 1ns/1ps
// ==========================================================================
// Self-checking bench for the supervisor
module cfp_supervisor_bench;
  localparam int HC = 16;
  logic       i_core_clk, i_rst, i_run_ctrl, i_reg_wr, i_reg_rd, i_strap_valid;
  logic       i_pwm_demand, i_ramp_done, i_sense_low, i_oc_trip, i_zero_current;
  logic       i_ov_trip, i_ov_clear, i_ot_trip, i_ot_clear, oc_cmd;
  logic       o_bus_id_valid, o_hs_gate, o_ls_gate, o_ramp_enable;
  logic       o_output_good_flag, o_bias_enable, o_fault_event;
  logic [1:0] o_oc_code, ov_lvl, ot_lvl;
  logic [2:0] i_strap_offset;
  logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, o_bus_id, o_ov_pct, o_ov_release_pct;
  logic [7:0] o_ot_deg, o_ot_release_deg;
  logic [9:0] strap_r;
  int         fails, cmp_count;
  cfp_supervisor #(.HICCUP_CYC(HC)) dut (.i_core_clk, .i_rst, .i_run_ctrl, .i_strap_offset,
    .i_strap_valid, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata, .i_pwm_demand,
    .i_ramp_done, .i_sense_low, .i_oc_trip, .i_zero_current, .i_ov_trip, .i_ov_clear,
    .i_ot_trip, .i_ot_clear, .o_reg_rdata, .o_bus_id, .o_bus_id_valid, .o_hs_gate,
    .o_ls_gate, .o_ramp_enable, .o_output_good_flag, .o_bias_enable, .o_oc_code, .o_ov_pct,
    .o_ov_release_pct, .o_ot_deg, .o_ot_release_deg, .o_fault_event);
  cfp_power_model u_pwr (.i_core_clk, .i_rst, .i_hs_gate(o_hs_gate), .i_ls_gate(o_ls_gate),
    .i_ramp_enable(o_ramp_enable), .i_oc_cmd(oc_cmd), .i_ov_lvl(ov_lvl), .i_ot_lvl(ot_lvl),
    .i_strap_r(strap_r), .o_strap_offset(i_strap_offset), .o_strap_valid(i_strap_valid),
    .o_pwm_demand(i_pwm_demand), .o_ramp_done(i_ramp_done), .o_sense_low(i_sense_low),
    .o_oc_trip(i_oc_trip), .o_zero_current(i_zero_current), .o_ov_trip(i_ov_trip),
    .o_ov_clear(i_ov_clear), .o_ot_trip(i_ot_trip), .o_ot_clear(i_ot_clear));
  always #12.5 i_core_clk = ~i_core_clk;
  // ==========================================================================
  // Shared tasks
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_reg_addr = a;
    i_reg_wdata = d;
    i_reg_wr = 1'b1;
    cyc(1);
    i_reg_wr = 1'b0;
    cyc(1);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    i_reg_addr = a;
    i_reg_rd = 1'b1;
    cyc(1);
    i_reg_rd = 1'b0;
    d = o_reg_rdata;
    cyc(1);
  endtask : rd
  task automatic go_up();
    int n;
    i_run_ctrl = 1'b1;
    for (n = 0; n < 800 && o_output_good_flag !== 1'b1; n++) cyc(1);
    if (n == 800) begin
      fails++;
      $display("MISMATCH %0t output good never rose", $time);
      finish_test();
    end
  endtask : go_up
  // ==========================================================================
  // Scenarios
  task automatic t_regs();
    logic [7:0] d;
    logic [7:0] ot [4];
    ot = '{cfp_pkg::OT_DEG_0, cfp_pkg::OT_DEG_1, cfp_pkg::OT_DEG_2, cfp_pkg::OT_DEG_3};
    chk({6'h00, o_oc_code}, 8'h02);
    chk(o_ov_pct, 8'h78);
    chk(o_ot_deg, ot[3]);
    rd(8'h15, d);
    chk(d, 8'h02);
    rd(8'h17, d);
    chk(d, 8'h03);
    rd(8'h19, d);
    chk(d, 8'h03);
    rd(cfp_pkg::BUS_ID_BASE_OFS, d);
    chk(d, 8'h08);
    wr(8'h20, 8'hFF);
    rd(8'h20, d);
    chk(d, 8'h00);
    for (int k = 0; k < 8; k++) begin
      wr(8'h15, 8'hF8 | k[7:0]);
      chk({6'h00, o_oc_code}, (k < 2) ? k[7:0] : 8'h02);
    end
    rd(8'h15, d);
    chk(d, 8'h07);
    for (int k = 0; k < 4; k++) begin
      wr(8'h17, k[7:0]);
      wr(8'h19, k[7:0]);
      chk(o_ov_pct, 8'h69 + 8'h05 * k[7:0]);
      chk(o_ov_release_pct, 8'h64 + 8'h05 * k[7:0]);
      chk(o_ot_deg, ot[k]);
      chk(o_ot_release_deg, ot[k] - 8'h19);
    end
    wr(8'h15, 8'h02);
  endtask : t_regs
  task automatic t_addr();
    chk({7'h00, o_bus_id_valid}, 8'h01);
    chk(o_bus_id, 8'h0D);
    strap_r = 10'h2A8;
    wr(cfp_pkg::BUS_ID_BASE_OFS, 8'h40);
    cyc(2);
    chk(o_bus_id, 8'h45);
    wr(cfp_pkg::BUS_ID_BASE_OFS, 8'h08);
    cyc(2);
    chk(o_bus_id, 8'h0D);
  endtask : t_addr
  task automatic t_run();
    go_up();
    chk({7'h00, o_output_good_flag}, 8'h01);
    i_run_ctrl = 1'b0;
    cyc(5);
    chk({4'h0, o_hs_gate, o_ls_gate, o_ramp_enable, o_output_good_flag}, 8'h00);
    cyc(20);
    chk({7'h00, o_hs_gate}, 8'h00);
  endtask : t_run
  task automatic t_oc();
    int   run;
    int   mx;
    int   rises;
    logic hp;
    logic fe;
    go_up();
    fe = 1'b0;
    oc_cmd = 1'b1;
    run = 0;
    mx = 0;
    rises = 0;
    hp = 1'b1;
    repeat (400) begin
      cyc(1);
      if (!o_hs_gate && !o_ls_gate) run++;
      else run = 0;
      if (run > mx) mx = run;
      if (o_hs_gate && !hp) rises++;
      hp = o_hs_gate;
      if (o_fault_event === 1'b1) fe = 1'b1;
    end
    chk({7'h00, mx >= HC}, 8'h01);
    chk({7'h00, rises >= 2}, 8'h01);
    chk({7'h00, fe}, 8'h01);
    chk({7'h00, o_output_good_flag}, 8'h00);
    oc_cmd = 1'b0;
    go_up();
  endtask : t_oc
  task automatic t_ov();
    ov_lvl = 2'h2;
    cyc(100);
    ov_lvl = 2'h1;
    cyc(2);
    chk({6'h00, o_hs_gate | o_ls_gate, o_output_good_flag}, 8'h03);
    ov_lvl = 2'h2;
    cyc(220);
    chk({5'h00, o_hs_gate, o_ls_gate, o_output_good_flag}, 8'h02);
    ov_lvl = 2'h0;
    cyc(8);
    chk({6'h00, o_hs_gate, o_ls_gate}, 8'h00);
    cyc(100);
    chk({6'h00, o_hs_gate, o_output_good_flag}, 8'h00);
    i_run_ctrl = 1'b0;
    cyc(8);
    go_up();
  endtask : t_ov
  task automatic t_ot();
    logic [7:0] d;
    ot_lvl = 2'h2;
    cyc(8);
    chk({5'h00, o_hs_gate, o_ls_gate, o_ramp_enable}, 8'h00);
    chk({7'h00, o_bias_enable}, 8'h01);
    ot_lvl = 2'h1;
    cyc(60);
    chk({7'h00, o_ramp_enable}, 8'h00);
    rd(cfp_pkg::FAULT_STATUS_OFS, d);
    chk(d, {5'h00, cfp_pkg::ST_OT_WAIT});
    ot_lvl = 2'h0;
    go_up();
  endtask : t_ot
  initial begin
    i_core_clk = 1'b0;
    i_rst = 1'b1;
    i_run_ctrl = 1'b0;
    i_reg_wr = 1'b0;
    i_reg_rd = 1'b0;
    i_reg_addr = 8'h00;
    i_reg_wdata = 8'h00;
    oc_cmd = 1'b0;
    ov_lvl = 2'h0;
    ot_lvl = 2'h0;
    strap_r = 10'h1D6;
    fails = 0;
    cmp_count = 0;
    repeat (10) @(posedge i_core_clk);
    #1;
    i_rst = 1'b0;
    cyc(12);
    t_regs();
    t_addr();
    t_run();
    t_oc();
    t_ov();
    t_ot();
    finish_test();
  end
endmodule : cfp_supervisor_bench
